// ==== rtl/spcs_map.vh ====
// register map, field positions, reset values and timing of the serial port
`ifndef SPCS_MAP_VH
`define SPCS_MAP_VH
`define SPCS_A_FRAME     8'h00
`define SPCS_A_CTRL2     8'h04
`define SPCS_A_DATA      8'h08
`define SPCS_A_STAT      8'h0c
`define SPCS_A_IRQ_STAT  8'h10
`define SPCS_A_IRQ_CLR   8'h14
`define SPCS_A_IRQ_EN    8'h18
`define SPCS_CTRL2_MASK  32'h000fdffe
`define SPCS_CTRL2_RST   32'h00000000
`define SPCS_FRAME_MASK  32'h0060001f
`define SPCS_FRAME_RST   32'h00000007
`define SPCS_B_EN        1
`define SPCS_B_MS        2
`define SPCS_B_SOD       3
`define SPCS_F_RXORD     5:4
`define SPCS_B_CRWAIT    6
`define SPCS_F_RXLVL     9:7
`define SPCS_F_TXLVL     12:10
`define SPCS_F_STDWAIT   17:14
`define SPCS_F_TXORD     19:18
`define SPCS_F_SIZE      4:0
`define SPCS_F_FMT       22:21
`define SPCS_FMT_STD     2'h0
`define SPCS_FMT_CR      2'h2
`define SPCS_LVL_1       3'h0
`define SPCS_LVL_4       3'h1
`define SPCS_LVL_8       3'h2
`define SPCS_ORD_MM      2'h0
`define SPCS_ORD_LM      2'h1
`define SPCS_ORD_ML      2'h2
`define SPCS_ORD_LL      2'h3
`define SPCS_FIFO_DEPTH  8
`define SPCS_CLK_MHZ     20
`define SPCS_HALF_NS     200
`define SPCS_HALF_CYC    ((`SPCS_HALF_NS * `SPCS_CLK_MHZ + 999) / 1000)
`endif

// ==== rtl/spcs_top.v ====
// serial port with second control register, fifos, interrupts and master/slave engine
`timescale 1ns/1ns
`include "spcs_map.vh"
module spcs_top (
  input  wire        clock,
  input  wire        reset,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  output reg         irq,
  input  wire        sclk_i,
  output reg         sclk_o,
  output reg         sclk_oe,
  input  wire        mosi_i,
  output reg         mosi_o,
  output reg         mosi_oe,
  input  wire        miso_i,
  output reg         miso_o,
  output reg         miso_oe,
  input  wire        ss_n_i,
  output reg         ss_n_o,
  output reg         ss_n_oe
);
  localparam [3:0] S_IDLE  = 4'h1;
  localparam [3:0] S_SHIFT = 4'h2;
  localparam [3:0] S_TURN  = 4'h4;
  localparam [3:0] S_GAP   = 4'h8;
  localparam integer HALF_CYC = `SPCS_HALF_CYC;
  localparam integer FIFO_N   = `SPCS_FIFO_DEPTH;
  localparam [7:0] HALF_LIM = HALF_CYC[7:0] - 8'h1;
  localparam [3:0] DEPTH   = FIFO_N[3:0];

  reg [31:0] ctrl_q;
  reg [31:0] frame_q;
  reg [3:0]  irq_st_q;
  reg [3:0]  irq_en_q;
  reg [31:0] tx_mem [0:7];
  reg [31:0] rx_mem [0:7];
  reg [2:0]  tx_rd_q, tx_wr_q, rx_rd_q, rx_wr_q;
  reg [3:0]  tx_cnt_q, rx_cnt_q;
  reg [2:0]  sck_sy, mosi_sy, miso_sy, ss_sy;
  reg [3:0]  st_q;
  reg [7:0]  tmr_q;
  reg [5:0]  bcnt_q;
  reg [4:0]  gcnt_q;
  reg        resp_q;
  reg        reload_q;
  reg [31:0] sr_q;
  reg [31:0] rsr_q;
  reg        push_q;
  reg        done_q;
  reg [31:0] rx_word_q;

  wire       en       = ctrl_q[`SPCS_B_EN];
  wire       master   = ~ctrl_q[`SPCS_B_MS];
  wire [1:0] rx_ord   = ctrl_q[`SPCS_F_RXORD];
  wire [1:0] tx_ord   = ctrl_q[`SPCS_F_TXORD];
  wire [1:0] fmt      = frame_q[`SPCS_F_FMT];
  wire       cmdresp  = (fmt == `SPCS_FMT_CR);
  wire [4:0] size     = frame_q[`SPCS_F_SIZE];
  wire [5:0] nbits    = (size < 5'd3) ? 6'd4 : ({1'b0, size} + 6'd1);

  // element reordering; each order is its own inverse at widths that are a multiple of 8, LM only when the width is a multiple of 8
  function [31:0] reorder;
    input [31:0] x;
    input [1:0]  ord;
    input [5:0]  n;
    integer      i;
    integer      j;
    reg [31:0]   r;
    begin
      r = 32'h0;
      for (i = 0; i < 32; i = i + 1)
      begin
        j = i;
        if (i < n)
        begin
          case (ord)
            `SPCS_ORD_LL: j = n - 1 - i;
            `SPCS_ORD_LM: if (n[2:0] == 3'h0) j = (n / 8 - 1 - i / 8) * 8 + i % 8;
            `SPCS_ORD_ML: j = (i / 8) * 8 + 7 - (i % 8);
            default:      j = i;
          endcase
          r[i] = x[j];
        end
      end
      reorder = r;
    end
  endfunction

  wire [31:0] tx_word  = reorder(tx_mem[tx_rd_q], tx_ord, nbits) << (6'd32 - nbits);
  wire        tx_avail = (tx_cnt_q != 4'h0);
  wire        half     = (tmr_q == HALF_LIM);
  wire        sck_rise = sck_sy[1] & ~sck_sy[2];
  wire        sck_fall = ~sck_sy[1] & sck_sy[2];
  wire        ss_fall  = ~ss_sy[1] & ss_sy[2];
  wire        s_act    = en & ~master & ~ss_sy[1];
  wire        m_start  = en & master & (st_q == S_IDLE) & tx_avail;
  wire        s_pop    = en & ~master & tx_avail & (ss_fall | (s_act & sck_fall & reload_q));
  wire        tx_pop   = m_start | s_pop;
  wire        tx_push  = wr & (addr == `SPCS_A_DATA) & (tx_cnt_q != DEPTH);
  wire        rx_pop   = rd & (addr == `SPCS_A_DATA) & (rx_cnt_q != 4'h0);
  wire        rx_ok    = push_q & (rx_cnt_q != DEPTH);
  wire        rx_ovr   = push_q & (rx_cnt_q == DEPTH);

  // fifo fill threshold; reserved codes never fire
  function lvl_hit;
    input [2:0] sel;
    input [3:0] cnt;
    begin
      case (sel)
        `SPCS_LVL_1: lvl_hit = (cnt >= 4'h1);
        `SPCS_LVL_4: lvl_hit = (cnt >= 4'h4);
        `SPCS_LVL_8: lvl_hit = (cnt >= 4'h8);
        default:     lvl_hit = 1'b0;
      endcase
    end
  endfunction

  wire [3:0] events = {done_q, rx_ovr,
                       lvl_hit(ctrl_q[`SPCS_F_TXLVL], tx_cnt_q),
                       lvl_hit(ctrl_q[`SPCS_F_RXLVL], rx_cnt_q)};

  // register slave
  always @(posedge clock)
  begin
    if (reset)
    begin
      ctrl_q   <= `SPCS_CTRL2_RST;
      frame_q  <= `SPCS_FRAME_RST;
      irq_en_q <= 4'h0;
      irq_st_q <= 4'h0;
      irq      <= 1'b0;
      rdata    <= 32'h0;
    end
    else
    begin
      if (wr & (addr == `SPCS_A_CTRL2))
        ctrl_q <= wdata & `SPCS_CTRL2_MASK;
      if (wr & (addr == `SPCS_A_FRAME))
        frame_q <= wdata & `SPCS_FRAME_MASK;
      if (wr & (addr == `SPCS_A_IRQ_EN))
        irq_en_q <= wdata[3:0];
      // set wins over clear
      if (wr & (addr == `SPCS_A_IRQ_CLR))
        irq_st_q <= (irq_st_q & ~wdata[3:0]) | events;
      else
        irq_st_q <= irq_st_q | events;
      irq <= |(irq_st_q & irq_en_q);
      rdata <= 32'h0;
      if (rd)
      begin
        case (addr)
          `SPCS_A_FRAME:    rdata <= frame_q;
          `SPCS_A_CTRL2:    rdata <= ctrl_q;
          `SPCS_A_DATA:     rdata <= rx_mem[rx_rd_q];
          `SPCS_A_STAT:     rdata <= {23'h0, ~(st_q == S_IDLE), tx_cnt_q, rx_cnt_q};
          `SPCS_A_IRQ_STAT: rdata <= {28'h0, irq_st_q};
          `SPCS_A_IRQ_EN:   rdata <= {28'h0, irq_en_q};
          default:          rdata <= 32'h0;
        endcase
      end
    end
  end

  // fifos
  always @(posedge clock)
  begin
    if (reset)
    begin
      tx_rd_q  <= 3'h0;
      tx_wr_q  <= 3'h0;
      tx_cnt_q <= 4'h0;
      rx_rd_q  <= 3'h0;
      rx_wr_q  <= 3'h0;
      rx_cnt_q <= 4'h0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_mem[tx_wr_q] <= wdata;
        tx_wr_q <= tx_wr_q + 3'h1;
      end
      if (tx_pop)
        tx_rd_q <= tx_rd_q + 3'h1;
      if (tx_push & ~tx_pop)
        tx_cnt_q <= tx_cnt_q + 4'h1;
      else if (tx_pop & ~tx_push)
        tx_cnt_q <= tx_cnt_q - 4'h1;
      if (rx_ok)
      begin
        rx_mem[rx_wr_q] <= rx_word_q;
        rx_wr_q <= rx_wr_q + 3'h1;
      end
      if (rx_pop)
        rx_rd_q <= rx_rd_q + 3'h1;
      if (rx_ok & ~rx_pop)
        rx_cnt_q <= rx_cnt_q + 4'h1;
      else if (rx_pop & ~rx_ok)
        rx_cnt_q <= rx_cnt_q - 4'h1;
    end
  end

  // pin synchronisers; stage 0 feeds stage 1 only
  always @(posedge clock)
  begin
    if (reset)
    begin
      sck_sy  <= 3'h0;
      mosi_sy <= 3'h0;
      miso_sy <= 3'h0;
      ss_sy   <= 3'h7;
    end
    else
    begin
      sck_sy  <= {sck_sy[1:0], sclk_i};
      mosi_sy <= {mosi_sy[1:0], mosi_i};
      miso_sy <= {miso_sy[1:0], miso_i};
      ss_sy   <= {ss_sy[1:0], ss_n_i};
    end
  end

  // serial engine
  always @(posedge clock)
  begin
    if (reset)
    begin
      st_q      <= S_IDLE;
      tmr_q     <= 8'h0;
      bcnt_q    <= 6'h0;
      gcnt_q    <= 5'h0;
      resp_q    <= 1'b0;
      reload_q  <= 1'b0;
      sr_q      <= 32'h0;
      rsr_q     <= 32'h0;
      push_q    <= 1'b0;
      done_q    <= 1'b0;
      rx_word_q <= 32'h0;
      sclk_o    <= 1'b0;
      sclk_oe   <= 1'b0;
      mosi_o    <= 1'b0;
      mosi_oe   <= 1'b0;
      miso_o    <= 1'b0;
      miso_oe   <= 1'b0;
      ss_n_o    <= 1'b1;
      ss_n_oe   <= 1'b0;
    end
    else
    begin
      push_q  <= 1'b0;
      done_q  <= 1'b0;
      sclk_oe <= en & master;
      mosi_oe <= en & master;
      ss_n_oe <= en & master;
      miso_oe <= s_act & ~ctrl_q[`SPCS_B_SOD];
      if (~en | ~master)
      begin
        st_q   <= S_IDLE;
        tmr_q  <= 8'h0;
        sclk_o <= 1'b0;
        ss_n_o <= 1'b1;
        mosi_o <= 1'b0;
      end
      if (en & ~master)
      begin
        // slave, clock idle low, sample on rise, shift on fall
        if (ss_fall)
        begin
          sr_q     <= tx_avail ? tx_word : 32'h0;
          miso_o   <= tx_avail & tx_word[31];
          bcnt_q   <= 6'h0;
          reload_q <= 1'b0;
          rsr_q    <= 32'h0;
        end
        else if (s_act & sck_rise)
        begin
          rsr_q <= {rsr_q[30:0], mosi_sy[1]};
          if (bcnt_q == nbits - 6'd1)
          begin
            push_q    <= 1'b1;
            done_q    <= 1'b1;
            rx_word_q <= reorder({rsr_q[30:0], mosi_sy[1]}, rx_ord, nbits);
            bcnt_q    <= 6'h0;
            reload_q  <= 1'b1;
          end
          else
            bcnt_q <= bcnt_q + 6'd1;
        end
        else if (s_act & sck_fall)
        begin
          if (reload_q)
          begin
            sr_q     <= tx_avail ? tx_word : 32'h0;
            miso_o   <= tx_avail & tx_word[31];
            reload_q <= 1'b0;
          end
          else
          begin
            sr_q   <= {sr_q[30:0], 1'b0};
            miso_o <= sr_q[30];
          end
        end
      end
      else if (en)
      begin
        tmr_q <= (half | (st_q == S_IDLE)) ? 8'h0 : tmr_q + 8'h1;
        case (st_q)
          S_IDLE:
          begin
            sclk_o <= 1'b0;
            ss_n_o <= 1'b1;
            if (m_start)
            begin
              sr_q   <= tx_word;
              mosi_o <= tx_word[31];
              ss_n_o <= 1'b0;
              bcnt_q <= 6'h0;
              resp_q <= 1'b0;
              rsr_q  <= 32'h0;
              st_q   <= S_SHIFT;
            end
          end
          S_SHIFT:
          begin
            if (half & ~sclk_o)
            begin
              sclk_o <= 1'b1;
              rsr_q  <= {rsr_q[30:0], miso_sy[1]};
            end
            else if (half)
            begin
              sclk_o <= 1'b0;
              sr_q   <= {sr_q[30:0], 1'b0};
              mosi_o <= ~resp_q & sr_q[30];
              if (bcnt_q != nbits - 6'd1)
                bcnt_q <= bcnt_q + 6'd1;
              else if (cmdresp & ~resp_q)
              begin
                // command sent, turn round for the response
                bcnt_q <= 6'h0;
                resp_q <= 1'b1;
                rsr_q  <= 32'h0;
                mosi_o <= 1'b0;
                gcnt_q <= 5'h1;
                st_q   <= ctrl_q[`SPCS_B_CRWAIT] ? S_TURN : S_SHIFT;
              end
              else
              begin
                bcnt_q    <= 6'h0;
                push_q    <= 1'b1;
                done_q    <= 1'b1;
                rx_word_q <= reorder(rsr_q, rx_ord, nbits);
                ss_n_o    <= 1'b1;
                mosi_o    <= 1'b0;
                gcnt_q    <= (fmt == `SPCS_FMT_STD) ?
                             {ctrl_q[`SPCS_F_STDWAIT], 1'b0} : 5'h0;
                st_q      <= S_GAP;
              end
            end
          end
          S_TURN, S_GAP:
          begin
            if (half)
            begin
              if (gcnt_q != 5'h0)
                gcnt_q <= gcnt_q - 5'h1;
              else
                st_q <= (st_q == S_TURN) ? S_SHIFT : S_IDLE;
            end
          end
          default:
            st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // spcs_top

// ==== tb/spcs_slave_model.sv ====
// far-side serial slave: shifts a fixed pattern out and records what it receives
`timescale 1ns/1ns
module spcs_slave_model #(
  parameter logic [31:0] PAT = 32'ha5c3_96f0
) (
  input  wire logic        sclk,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic [31:0]      got
);
  logic [31:0] sh = PAT;
  // reload while deselected, rotate on each falling clock
  always @(negedge sclk or posedge ss_n)
    sh <= ss_n ? PAT : {sh[30:0], sh[31]};
  // clear on select, shift in on each rising clock
  always @(posedge sclk or negedge ss_n)
    if (!sclk)
      got <= 32'h0;
    else if (!ss_n)
      got <= {got[30:0], mosi};
  // released line shows the inverse of the pattern's first bit
  assign miso = ss_n ? ~sh[31] : sh[31];
endmodule // spcs_slave_model

// ==== tb/spcs_sva.sv ====
// assertions on bus, pin enables, frame timing and interrupt mask of the serial port
`timescale 1ns/1ns
`include "spcs_map.vh"
module spcs_sva (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq,
  input wire logic        sclk_i,
  input wire logic        sclk_o,
  input wire logic        sclk_oe,
  input wire logic        mosi_i,
  input wire logic        mosi_o,
  input wire logic        mosi_oe,
  input wire logic        miso_i,
  input wire logic        miso_o,
  input wire logic        miso_oe,
  input wire logic        ss_n_i,
  input wire logic        ss_n_o,
  input wire logic        ss_n_oe
);
  logic [31:0] ctrl_q;
  logic [1:0]  fmt_q;
  logic [3:0]  ien_q;
  logic [7:0]  hi_q;
  logic        chg_q;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  always @(posedge clock)
    if (reset)
    begin
      ctrl_q <= 32'h0;
      fmt_q <= 2'h0;
      ien_q <= 4'h0;
      hi_q <= 8'h0;
      chg_q <= 1'b1;
    end
    else
    begin
      if (wr && addr == `SPCS_A_CTRL2)
        ctrl_q <= wdata & `SPCS_CTRL2_MASK;
      if (wr && addr == `SPCS_A_FRAME)
        fmt_q <= wdata[22:21];
      if (wr && addr == `SPCS_A_IRQ_EN)
        ien_q <= wdata[3:0];
      hi_q <= !ss_n_o ? 8'h0 : hi_q + {7'h0, hi_q != 8'hff};
      // config touched between frames: gap figure not comparable
      chg_q <= !ss_n_o ? 1'b0 : chg_q | (wr && addr inside {`SPCS_A_CTRL2, `SPCS_A_FRAME});
    end
  sequence s_lead;
    !sclk_o [*4] ##1 sclk_o;
  endsequence
  sequence s_high;
    sclk_o [*4] ##1 !sclk_o;
  endsequence
  property p_rd_idle;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_ctrl_read;
    rd && addr == `SPCS_A_CTRL2 |=> rdata == $past(ctrl_q);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");
  property p_master_oe;
    sclk_oe == $past(ctrl_q[1] & ~ctrl_q[2]);
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("clock enable wrong");
  property p_oe_pair;
    mosi_oe == sclk_oe && ss_n_oe == sclk_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("master enables differ");
  property p_miso_oe;
    miso_oe |-> $past(ctrl_q[1] & ctrl_q[2] & ~ctrl_q[3]);
  endproperty
  a_miso_oe: assert property (p_miso_oe) else $error("data out driven");
  property p_lead;
    $fell(ss_n_o) |-> s_lead;
  endproperty
  a_lead: assert property (p_lead) else $error("frame lead wrong");
  property p_half;
    $rose(sclk_o) |-> s_high;
  endproperty
  a_half: assert property (p_half) else $error("clock half period wrong");
  property p_gap;
    $fell(ss_n_o) && fmt_q == 2'h0 && !chg_q |-> hi_q >= {1'b0, ctrl_q[17:14], 3'h4};
  endproperty
  a_gap: assert property (p_gap) else $error("gap between frames short");
  property p_irq_mask;
    $past(ien_q) == 4'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
endmodule // spcs_sva
bind spcs_top spcs_sva chk (.clock, .reset, .addr, .wdata, .wr, .rd, .rdata, .irq, .sclk_i,
  .sclk_o, .sclk_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i, .ss_n_o,
  .ss_n_oe);

// ==== tb/tb.sv ====
// register-level bench for the serial port with a far-side slave model
`timescale 1ns/1ns
`include "spcs_map.vh"
module tb;
  localparam logic [31:0] PAT = 32'ha5c3_96f0;
  logic clock, reset, wr, rd, irq, sclk_i, sclk_o, sclk_oe, mosi_i, mosi_o, mosi_oe;
  logic miso_i, miso_o, miso_oe, ss_n_i, ss_n_o, ss_n_oe, pm_miso;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, got, d, x, msk;
  int          fail_count, total_checks, n, o, len, lens[3], thr[3] = '{1, 4, 8};
  logic        e;
  assign miso_i = miso_oe ? miso_o : pm_miso;
  spcs_top dut (.clock, .reset, .addr, .wdata, .wr, .rd, .rdata, .irq, .sclk_i, .sclk_o,
    .sclk_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i, .ss_n_o,
    .ss_n_oe);
  spcs_slave_model #(.PAT(PAT)) m (.sclk(sclk_o), .ss_n(ss_n_o), .mosi(mosi_o),
    .miso(pm_miso), .got);
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    total_checks++;
    if (g !== ex)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_ss(input logic v, output int c);
    for (c = 0; ss_n_o !== v; c++)
    begin
      if (c == 4000)
      begin
        fail_count++;
        final_report;
      end
      @(posedge clock);
    end
  endtask
  task automatic frame(output int c);
    wait_ss(1'b0, c);
    wait_ss(1'b1, c);
  endtask
  function automatic logic [31:0] reord(input logic [31:0] v, input int od, input int nb);
    logic [31:0] y;
    int j;
    y = 32'h0;
    for (int i = 0; i < nb; i++)
    begin
      j = od == 0 ? i : od == 3 ? nb - 1 - i : od == 1 ? (nb / 8 - 1 - i / 8) * 8 + i % 8
        : i / 8 * 8 + 7 - i % 8;
      y[j] = v[i];
    end
    return y;
  endfunction
  initial
  begin
    reset = 1'b1;
    {wr, rd, sclk_i, mosi_i, ss_n_i} = 5'h01;
    addr = 8'h0;
    wdata = 32'h0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rreg(`SPCS_A_CTRL2, d);
    chk("ctrl reset", 32'h0, d);
    wreg(`SPCS_A_CTRL2, 32'hffffffff);
    rreg(`SPCS_A_CTRL2, d);
    chk("ctrl reserved", `SPCS_CTRL2_MASK, d);
    wreg(`SPCS_A_CTRL2, 32'h0);
    rreg(8'h1c, d);
    chk("unmapped", 32'h0, d);
    $display("test registers done");
    // mixed orders only with 16-bit frames
    for (int k = 0; k < 6; k++)
    begin
      n = k < 4 ? 16 : 4;
      o = k < 4 ? k : (k - 4) * 3;
      msk = 32'hffffffff >> (32 - n);
      x = 32'h1234b6e9 & msk;
      wreg(`SPCS_A_FRAME, 32'(n - 1));
      wreg(`SPCS_A_CTRL2, 32'h2 | 32'(o) << 4 | 32'(o) << 18);
      wreg(`SPCS_A_DATA, x);
      frame(len);
      chk("tx order", reord(x, o, n), got & msk);
      rreg(`SPCS_A_IRQ_STAT, d);
      chk("rx level", 32'h1, d & 32'h1);
      rreg(`SPCS_A_DATA, d);
      chk("rx order", reord(PAT >> (32 - n), o, n), d);
      wreg(`SPCS_A_IRQ_CLR, 32'h1);
    end
    $display("test orders done");
    for (int k = 0; k < 3; k++)
    begin
      wreg(`SPCS_A_FRAME, k == 0 ? 32'h7 : 32'h0040_0007);
      wreg(`SPCS_A_CTRL2, k == 2 ? 32'h42 : 32'h2);
      wreg(`SPCS_A_DATA, 32'h5a);
      frame(lens[k]);
    end
    chk("format", 32'd64, 32'(lens[1] - lens[0]));
    chk("cr wait", 32'd8, 32'(lens[2] - lens[1]));
    $display("test formats done");
    wreg(`SPCS_A_FRAME, 32'h7);
    for (int k = 0; k < 2; k++)
    begin
      wreg(`SPCS_A_CTRL2, 32'h2 | 32'(k * 3) << 14);
      wreg(`SPCS_A_DATA, 32'h3c);
      wreg(`SPCS_A_DATA, 32'hc3);
      frame(len);
      wait_ss(1'b0, lens[k]);
      frame(len);
    end
    chk("std gap", 32'd24, 32'(lens[1] - lens[0]));
    $display("test gaps done");
    wreg(`SPCS_A_CTRL2, 32'h6);
    ss_n_i <= 1'b0;
    repeat (6) @(posedge clock);
    chk("slave out", 32'h1, {31'h0, miso_oe});
    chk("slave clk", 32'h0, {31'h0, sclk_oe});
    wreg(`SPCS_A_CTRL2, 32'he);
    repeat (3) @(posedge clock);
    chk("out off", 32'h0, {31'h0, miso_oe});
    ss_n_i <= 1'b1;
    rreg(`SPCS_A_STAT, d);
    chk("rx count", 32'h7, d & 32'hf);
    repeat (d[3:0]) rreg(`SPCS_A_DATA, x);
    // slave frame, bit-reversed both ways, link clock of 400 ns
    wreg(`SPCS_A_CTRL2, 32'h000c0036);
    wreg(`SPCS_A_DATA, 32'h3a);
    ss_n_i <= 1'b0;
    x = 32'h0;
    msk = 32'h96;
    repeat (6) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      mosi_i <= msk[7 - i];
      repeat (4) @(posedge clock);
      sclk_i <= 1'b1;
      x = {x[30:0], miso_o};
      repeat (4) @(posedge clock);
      sclk_i <= 1'b0;
    end
    repeat (6) @(posedge clock);
    ss_n_i <= 1'b1;
    chk("slave tx", reord(32'h3a, 3, 8), x);
    rreg(`SPCS_A_DATA, d);
    chk("slave rx", reord(msk, 3, 8), d);
    $display("test slave done");
    wreg(`SPCS_A_CTRL2, 32'h0);
    wreg(`SPCS_A_IRQ_EN, 32'h2);
    for (int k = 1; k <= 8; k++)
    begin
      wreg(`SPCS_A_DATA, 32'(k));
      for (int c = 0; c < 4; c++)
      begin
        e = c < 3 && k >= thr[c % 3];
        wreg(`SPCS_A_CTRL2, 32'(c) << 10);
        wreg(`SPCS_A_IRQ_CLR, 32'h3);
        rreg(`SPCS_A_IRQ_STAT, d);
        chk("tx level", {31'h0, e}, {31'h0, d[1]});
        chk("irq", {31'h0, e}, {31'h0, irq});
      end
    end
    wreg(`SPCS_A_IRQ_EN, 32'h0);
    repeat (3) @(posedge clock);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test interrupts done");
    final_report;
  end
endmodule // tb
